// *** shared/cip_pkg.sv ***
// shared constants, state codes and frame helpers for the identification link
package cip_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int IDENTIFICATION_CLOCK_RATE = 3125000;
   localparam int ID_HALF_CYCLES = CLK_HZ / (2 * IDENTIFICATION_CLOCK_RATE);
   localparam int CMD_BITS = 48;
   localparam int CID_RSP_BITS = 136;
   localparam int RSP_GAP_BITS = 2;
   localparam int ID_TIMEOUT_PERIODS = 5;
   localparam int RSP_TIMEOUT_PERIODS = 64;
   localparam int CMD_GAP_PERIODS = 8;
   localparam logic [15:0] POWERUP_CYCLES = 16'h07D0;
   localparam logic [5:0] CMD_GO_IDLE = 6'h00;
   localparam logic [5:0] CMD_SEND_OP_COND = 6'h01;
   localparam logic [5:0] CMD_ALL_SEND_ID = 6'h02;
   localparam logic [5:0] CMD_SET_REL_ADDR = 6'h03;
   localparam logic [5:0] CMD_APP_PREFIX = 6'h37;
   localparam logic [5:0] CMD_GEN_TRANSFER = 6'h38;
   localparam logic [5:0] RSP_LONG_INDEX = 6'h3F;
   localparam logic [31:0] OCR_READY = 32'h80FF8000;
   localparam logic [31:0] OCR_BUSY = 32'h00FF8000;
   localparam logic [31:0] OCR_VOLT_MASK = 32'h00FFFF00;
   localparam logic [31:0] STATUS_IDENT = 32'h00000400;
   localparam logic [15:0] FIRST_RCA = 16'h0001;
   // arbitrary identification number, override per card
   localparam logic [127:0] CID_DEFAULT = 128'h0123456789ABCDEF0011223344556677;

   typedef enum logic [2:0] {
      CS_IDLE = 3'b000,
      CS_READY = 3'b001,
      CS_IDENT = 3'b010,
      CS_STBY = 3'b011,
      CS_INACTIVE = 3'b100
   } cip_card_state_t;

   function automatic logic [6:0] cip_crc7(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ 7'h09;
         end
      end
      return c;
   endfunction

   // start, direction, index, argument, crc (or all ones), end
   function automatic logic [47:0] cip_frame(input logic from_host, input logic [5:0] idx,
                                             input logic [31:0] arg, input logic crc_on);
      logic [6:0] crc;
      crc = crc_on ? cip_crc7({1'b0, from_host, idx, arg}) : 7'h7F;
      return {1'b0, from_host, idx, arg, crc, 1'b1};
   endfunction

   function automatic logic cip_is_unsupported(input logic [5:0] idx);
      return idx inside {6'h05, 6'h06, 6'h08, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h1F, 6'h27,
                         6'h28, 6'h29, [6'h2B:6'h36], CMD_APP_PREFIX, CMD_GEN_TRANSFER,
                         [6'h39:6'h3F]};
   endfunction
endpackage

// *** shared/cip_link_if.sv ***
// link between host controller and card stack: clock, wired command line, data line
`timescale 1ns/1ps
interface cip_link_if #(parameter int NCARD = 2);
   logic mclk;
   logic host_cmd_o;
   logic host_cmd_oe_n;
   logic [NCARD-1:0] card_cmd_o;
   logic [NCARD-1:0] card_cmd_oe_n;
   logic [NCARD-1:0] card_dat_oe_n;
   logic cmd;
   logic dat;

   // pulled-up lines: any enabled low driver pulls them down
   always_comb begin
      cmd = host_cmd_oe_n | host_cmd_o;
      for (int i = 0; i < NCARD; i++) begin
         cmd = cmd & (card_cmd_oe_n[i] | card_cmd_o[i]);
      end
      dat = &card_dat_oe_n;
   end

   modport host (output mclk, output host_cmd_o, output host_cmd_oe_n, input cmd);
   modport card (input mclk, input cmd, output card_cmd_o, output card_cmd_oe_n,
                 output card_dat_oe_n);
endinterface

// *** rtl/cip_card.sv ***
// card end of the identification phase: operating conditions, arbitration, address
`timescale 1ns/1ps
// Notes on behaviour
// - application prefix command is refused, no effect
// - general block transfer command is refused
// - argument bit zero picks direction; refused anyway
// - identification uses command line only
// - identification starts open-drain at slow rate
// - op-condition answers from all cards wire together
// - out-of-range cards go inactive
// - busy bit held during power-up; host repeats
// - ready cards shift identity out, checking line
// - mismatch stops sending, card stays ready
// - full identity sent moves to identification state
// - address assigned: standby, ignore identification
// - standby switches drivers to push-pull
// - host repeats until no start in 5 periods
// - op-condition value ready 80FF8000, busy 00FF8000
module cip_card
   import cip_pkg::*;
#(
   parameter int CARD_IDX = 0,
   parameter logic [127:0] CID = CID_DEFAULT
) (
   input logic clk,
   input logic rst_n,
   cip_link_if.card link,
   output cip_card_state_t card_state,
   output logic [15:0] rca,
   output logic push_pull,
   output logic illegal_cmd
);

   localparam int TX_W = RSP_GAP_BITS + CID_RSP_BITS;

   typedef struct packed {
      logic mclk_s1;
      logic mclk_s2;
      logic mclk_d;
      logic cmd_s1;
      logic cmd_s2;
      cip_card_state_t state;
      logic [15:0] pwr_cnt;
      logic busy;
      logic rx_on;
      logic [5:0] rx_cnt;
      logic [45:0] rx_sh;
      logic tx_on;
      logic [7:0] tx_cnt;
      logic [TX_W-1:0] tx_sh;
      logic tx_cid;
      logic lost;
      logic cur_bit;
      logic cur_od;
      logic cmd_o;
      logic cmd_oe_n;
      logic dat_oe_n;
      logic [15:0] rca;
      logic push_pull;
      logic illegal;
   } cip_card_reg_t;

   cip_card_reg_t st;
   cip_card_reg_t next_st;

   always_comb begin
      logic rise;
      logic fall;
      logic ok;
      logic load48;
      logic [47:0] frame;
      logic [47:0] rsp48;
      logic [5:0] idx;
      logic [31:0] arg;
      next_st = st;
      rise = 1'b0;
      fall = 1'b0;
      ok = 1'b0;
      load48 = 1'b0;
      frame = 48'h000000000000;
      rsp48 = 48'hFFFFFFFFFFFF;
      idx = 6'h00;
      arg = 32'h00000000;
      next_st.illegal = 1'b0;
      next_st.dat_oe_n = 1'b1;
      // link clock comes from the host: sync it, then find its edges
      next_st.mclk_s1 = link.mclk;
      next_st.mclk_s2 = st.mclk_s1;
      next_st.mclk_d = st.mclk_s2;
      next_st.cmd_s1 = link.cmd;
      next_st.cmd_s2 = st.cmd_s1;
      rise = st.mclk_s2 & ~st.mclk_d;
      fall = ~st.mclk_s2 & st.mclk_d;

      // power-up procedure keeps the busy indication active
      if (st.busy) begin
         if (st.pwr_cnt == POWERUP_CYCLES - 16'h0001) begin
            next_st.busy = 1'b0;
         end else begin
            next_st.pwr_cnt = st.pwr_cnt + 16'h0001;
         end
      end

      // outgoing bits change on the falling link edge
      if (st.tx_on && fall) begin
         if (st.tx_cnt == 8'h00) begin
            next_st.tx_on = 1'b0;
            next_st.cmd_o = 1'b0;
            next_st.cmd_oe_n = 1'b1;
            if (st.tx_cid && !st.lost) begin
               next_st.state = CS_IDENT;
            end
         end else begin
            next_st.cur_bit = st.tx_sh[TX_W-1];
            next_st.tx_sh = {st.tx_sh[TX_W-2:0], 1'b1};
            next_st.tx_cnt = st.tx_cnt - 8'h01;
            if (!st.lost) begin
               if (st.cur_od) begin
                  // open drain: only a zero is driven, a one lets the line float
                  next_st.cmd_o = 1'b0;
                  next_st.cmd_oe_n = st.tx_sh[TX_W-1];
               end else begin
                  // push-pull, but off the line through the filler until the start bit
                  next_st.cmd_o = st.tx_sh[TX_W-1];
                  next_st.cmd_oe_n = st.cmd_oe_n & st.tx_sh[TX_W-1];
               end
            end
         end
      end

      // a loser keeps counting silently so it never mistakes the winner's bits for a command
      if (st.tx_on && rise && st.tx_cid && !st.lost && (st.cmd_s2 != st.cur_bit)) begin
         next_st.lost = 1'b1;
         next_st.cmd_oe_n = 1'b1;
      end

      // incoming command bits are taken on the rising link edge
      if (!st.tx_on && rise) begin
         if (!st.rx_on) begin
            if (!st.cmd_s2) begin
               next_st.rx_on = 1'b1;
               next_st.rx_cnt = 6'(CMD_BITS - 1);
            end
         end else begin
            next_st.rx_sh = {st.rx_sh[44:0], st.cmd_s2};
            next_st.rx_cnt = st.rx_cnt - 6'h01;
            if (st.rx_cnt == 6'h01) begin
               next_st.rx_on = 1'b0;
               frame = {1'b0, st.rx_sh, st.cmd_s2};
               idx = frame[45:40];
               arg = frame[39:8];
               ok = frame[46] & frame[0] & (frame[7:1] == cip_crc7(frame[47:8]));
            end
         end
      end

      if (ok) begin
         unique case (idx)
            CMD_GO_IDLE: begin
               if (st.state != CS_INACTIVE) begin
                  next_st.state = CS_IDLE;
                  next_st.push_pull = 1'b0;
               end
            end
            CMD_SEND_OP_COND: begin
               // standby and later ignore the identification flow
               if (st.state == CS_IDLE || st.state == CS_READY) begin
                  if (arg != 32'h00000000 && (arg & OCR_VOLT_MASK & OCR_READY) == 32'h00000000)
                  begin
                     next_st.state = CS_INACTIVE;
                  end else begin
                     load48 = 1'b1;
                     rsp48 = cip_frame(1'b0, RSP_LONG_INDEX, st.busy ? OCR_BUSY : OCR_READY,
                                       1'b0);
                     // an empty argument is only a query of the stack
                     if (!st.busy && arg != 32'h00000000) begin
                        next_st.state = CS_READY;
                     end
                  end
               end
            end
            CMD_ALL_SEND_ID: begin
               if (st.state == CS_READY) begin
                  next_st.tx_on = 1'b1;
                  next_st.tx_cid = 1'b1;
                  next_st.lost = 1'b0;
                  next_st.cur_bit = 1'b1;
                  next_st.cur_od = ~st.push_pull;
                  next_st.tx_sh = {2'b11, 2'b00, RSP_LONG_INDEX, CID[127:1], 1'b1};
                  next_st.tx_cnt = 8'(TX_W);
               end
            end
            CMD_SET_REL_ADDR: begin
               if (st.state == CS_IDENT) begin
                  next_st.rca = arg[31:16];
                  next_st.state = CS_STBY;
                  next_st.push_pull = 1'b1;
                  load48 = 1'b1;
                  rsp48 = cip_frame(1'b0, CMD_SET_REL_ADDR, STATUS_IDENT, 1'b1);
               end
            end
            default: begin
               // refused whatever the direction bit asks, and no data phase follows
               if (cip_is_unsupported(idx)) begin
                  next_st.illegal = 1'b1;
               end
            end
         endcase
      end

      if (load48) begin
         next_st.tx_on = 1'b1;
         next_st.tx_cid = 1'b0;
         next_st.lost = 1'b0;
         next_st.cur_bit = 1'b1;
         next_st.cur_od = ~next_st.push_pull;
         next_st.tx_sh = {2'b11, rsp48, {(TX_W - CMD_BITS - RSP_GAP_BITS){1'b1}}};
         next_st.tx_cnt = 8'(CMD_BITS + RSP_GAP_BITS);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.mclk_s1 <= 1'b0;
         st.cmd_s1 <= 1'b1;
         st.cmd_s2 <= 1'b1;
         st.busy <= 1'b1;
         st.cur_bit <= 1'b1;
         st.cur_od <= 1'b1;
         st.cmd_oe_n <= 1'b1;
         st.dat_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.card_cmd_o[CARD_IDX] = st.cmd_o;
   assign link.card_cmd_oe_n[CARD_IDX] = st.cmd_oe_n;
   assign link.card_dat_oe_n[CARD_IDX] = st.dat_oe_n;
   assign card_state = st.state;
   assign rca = st.rca;
   assign push_pull = st.push_pull;
   assign illegal_cmd = st.illegal;

endmodule // cip_card

// *** rtl/cip_host.sv ***
// host end of the identification phase: clock divider and identification sequence
`timescale 1ns/1ps
module cip_host
   import cip_pkg::*;
(
   input logic clk,
   input logic rst_n,
   cip_link_if.host link,
   input logic start,
   input logic [31:0] volt_window,
   output logic busy,
   output logic done,
   output logic no_card,
   output logic unusable,
   output logic [31:0] ocr_wired,
   output logic [7:0] card_count,
   output logic [15:0] last_rca,
   output logic [127:0] last_cid
);

   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_SEND = 3'b001,
      HS_WAIT = 3'b010,
      HS_RECV = 3'b011,
      HS_GAP = 3'b100
   } cip_host_state_t;

   typedef enum logic [1:0] {
      SP_QUERY = 2'b00,
      SP_OPCOND = 2'b01,
      SP_CID = 2'b10,
      SP_RCA = 2'b11
   } cip_host_step_t;

   typedef struct packed {
      logic [2:0] div_cnt;
      logic mclk;
      logic cmd_s1;
      logic cmd_s2;
      cip_host_state_t hs;
      cip_host_step_t step;
      logic [47:0] tx_sh;
      logic [7:0] cnt;
      logic [134:0] rx_sh;
      logic [31:0] ocr;
      logic [15:0] rca;
      logic [7:0] count;
      logic [15:0] last_rca;
      logic [127:0] cid;
      logic busy;
      logic done;
      logic no_card;
      logic unusable;
      logic cmd_o;
      logic cmd_oe_n;
   } cip_host_reg_t;

   cip_host_reg_t st;
   cip_host_reg_t next_st;

   always_comb begin
      logic tick;
      logic send;
      logic [5:0] s_idx;
      logic [31:0] s_arg;
      logic [134:0] rsp;
      logic [31:0] want;
      next_st = st;
      tick = 1'b0;
      send = 1'b0;
      s_idx = CMD_GO_IDLE;
      s_arg = 32'h00000000;
      rsp = {st.rx_sh[133:0], st.cmd_s2};
      want = volt_window & OCR_VOLT_MASK;
      next_st.cmd_s1 = link.cmd;
      next_st.cmd_s2 = st.cmd_s1;
      // free-running slow identification clock; tick marks the end of its high phase
      if (st.div_cnt == 3'(ID_HALF_CYCLES - 1)) begin
         next_st.div_cnt = 3'h0;
         next_st.mclk = ~st.mclk;
         tick = st.mclk;
      end else begin
         next_st.div_cnt = st.div_cnt + 3'h1;
      end

      unique case (st.hs)
         HS_IDLE: begin
            if (start) begin
               next_st.busy = 1'b1;
               next_st.done = 1'b0;
               next_st.no_card = 1'b0;
               next_st.unusable = 1'b0;
               next_st.count = 8'h00;
               next_st.rca = FIRST_RCA;
               next_st.step = SP_QUERY;
               send = 1'b1;
               s_idx = CMD_SEND_OP_COND;
            end
         end
         HS_SEND: begin
            if (tick) begin
               if (st.cnt == 8'h00) begin
                  next_st.cmd_oe_n = 1'b1;
                  next_st.hs = HS_WAIT;
               end else begin
                  next_st.cmd_o = st.tx_sh[47];
                  next_st.cmd_oe_n = 1'b0;
                  next_st.tx_sh = {st.tx_sh[46:0], 1'b1};
                  next_st.cnt = st.cnt - 8'h01;
               end
            end
         end
         HS_WAIT: begin
            if (tick) begin
               if (!st.cmd_s2) begin
                  next_st.hs = HS_RECV;
                  next_st.cnt = (st.step == SP_CID) ? 8'(CID_RSP_BITS - 1) : 8'(CMD_BITS - 1);
               end else if (st.step == SP_CID && st.cnt == 8'(ID_TIMEOUT_PERIODS)) begin
                  next_st.hs = HS_IDLE;
                  next_st.busy = 1'b0;
                  next_st.done = 1'b1;
               end else if (st.cnt == 8'(RSP_TIMEOUT_PERIODS)) begin
                  next_st.hs = HS_IDLE;
                  next_st.busy = 1'b0;
                  next_st.done = 1'b1;
                  next_st.no_card = 1'b1;
               end else begin
                  next_st.cnt = st.cnt + 8'h01;
               end
            end
         end
         HS_RECV: begin
            if (tick) begin
               next_st.rx_sh = rsp;
               next_st.cnt = st.cnt - 8'h01;
               if (st.cnt == 8'h01) begin
                  next_st.hs = HS_GAP;
                  next_st.cnt = 8'h00;
                  unique case (st.step)
                     SP_QUERY: begin
                        next_st.ocr = rsp[39:8];
                        next_st.unusable = (rsp[39:8] & want) != want;
                        next_st.step = SP_OPCOND;
                     end
                     SP_OPCOND: begin
                        // busy cards answer with the top bit low: ask again
                        if (rsp[39]) begin
                           next_st.step = SP_CID;
                        end
                     end
                     SP_CID: begin
                        next_st.cid = {rsp[127:1], 1'b1};
                        next_st.step = SP_RCA;
                     end
                     SP_RCA: begin
                        next_st.count = st.count + 8'h01;
                        next_st.last_rca = st.rca;
                        next_st.rca = st.rca + 16'h0001;
                        next_st.step = SP_CID;
                     end
                  endcase
               end
            end
         end
         HS_GAP: begin
            if (tick) begin
               next_st.cnt = st.cnt + 8'h01;
               if (st.cnt == 8'(CMD_GAP_PERIODS)) begin
                  send = 1'b1;
                  unique case (st.step)
                     SP_CID: s_idx = CMD_ALL_SEND_ID;
                     SP_RCA: begin
                        s_idx = CMD_SET_REL_ADDR;
                        s_arg = {st.rca, 16'h0000};
                     end
                     default: begin
                        s_idx = CMD_SEND_OP_COND;
                        s_arg = want;
                     end
                  endcase
               end
            end
         end
         default: next_st.hs = HS_IDLE;
      endcase

      if (send) begin
         next_st.hs = HS_SEND;
         next_st.tx_sh = cip_frame(1'b1, s_idx, s_arg, 1'b1);
         next_st.cnt = 8'(CMD_BITS);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.cmd_s1 <= 1'b1;
         st.cmd_s2 <= 1'b1;
         st.cmd_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.mclk = st.mclk;
   assign link.host_cmd_o = st.cmd_o;
   assign link.host_cmd_oe_n = st.cmd_oe_n;
   assign busy = st.busy;
   assign done = st.done;
   assign no_card = st.no_card;
   assign unusable = st.unusable;
   assign ocr_wired = st.ocr;
   assign card_count = st.count;
   assign last_rca = st.last_rca;
   assign last_cid = st.cid;

endmodule // cip_host

// *** tb/cip_link_chk.sv ***
// assertions on the identification link between host and card stack
`timescale 1ns/1ps
module cip_link_chk #(parameter int NCARD = 2) (
   input logic clk,
   input logic rst_n,
   input logic mclk,
   input logic host_cmd_o,
   input logic host_cmd_oe_n,
   input logic [NCARD-1:0] card_cmd_o,
   input logic [NCARD-1:0] card_cmd_oe_n,
   input logic [NCARD-1:0] card_dat_oe_n,
   input logic cmd,
   input logic dat
);
   logic [9:0] low_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles the host has held the line in the current frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) low_cnt <= 10'h000;
      else if (host_cmd_oe_n) low_cnt <= 10'h000;
      else low_cnt <= low_cnt + 10'h001;
   end
   dat_released_a: assert property (&card_dat_oe_n && dat)
      else $error("data line driven during identification");
   link_clock_a: assert property ($rose(mclk) |-> mclk[*4] ##1 !mclk)
      else $error("link clock high phase not four cycles");
   host_alone_a: assert property (!host_cmd_oe_n |-> &card_cmd_oe_n && cmd == host_cmd_o)
      else $error("card drives while host sends");
   host_start_a: assert property ($fell(host_cmd_oe_n) |-> !host_cmd_o)
      else $error("host frame without start bit");
   frame_len_a: assert property ($rose(host_cmd_oe_n) |-> low_cnt == 10'h180 && $past(host_cmd_o))
      else $error("host frame not 48 periods or no end bit");
   resp_gap_a: assert property ($rose(host_cmd_oe_n) |-> (&card_cmd_oe_n)[*8])
      else $error("card answer starts too early");
   card0_start_a: assert property ($fell(card_cmd_oe_n[0]) |-> !card_cmd_o[0])
      else $error("card 0 answer not started low");
   card1_start_a: assert property ($fell(card_cmd_oe_n[1]) |-> !card_cmd_o[1])
      else $error("card 1 answer not started low");
endmodule // cip_link_chk

// *** tb/card_identification_protocol_tb.sv ***
// bench: host and two cards on one link, a third card driven directly by the bench
`timescale 1ns/1ps
module card_identification_protocol_tb;
   import cip_pkg::*;
   // arbitrary second identity, sorts above the default one
   localparam logic [127:0] CID_B = 128'h4123456789ABCDEF0011223344556677;
   logic clk = 1'b0;
   logic rst_n, start, busy, done, no_card, unusable;
   logic [31:0] volt_window, ocr_wired, rs;
   logic [7:0] card_count;
   logic [15:0] last_rca;
   logic [127:0] last_cid;
   logic [63:0] cap = 64'h0;
   cip_card_state_t st [3];
   logic [15:0] rc [3];
   logic pp [3];
   logic il [3];
   int n_fail = 0;
   int compares = 0;
   int n_ill = 0;
   int n_ill_stk = 0;
   cip_link_if #(.NCARD(2)) l1 ();
   cip_link_if #(.NCARD(1)) l2 ();
   cip_host cip_host_inst (.clk(clk), .rst_n(rst_n), .link(l1.host), .start(start),
      .volt_window(volt_window), .busy(busy), .done(done), .no_card(no_card),
      .unusable(unusable), .ocr_wired(ocr_wired), .card_count(card_count),
      .last_rca(last_rca), .last_cid(last_cid));
   for (genvar i = 0; i < 2; i++) begin : g_card
      cip_card #(.CARD_IDX(i), .CID(i ? CID_B : CID_DEFAULT)) cip_card_inst (.clk(clk),
         .rst_n(rst_n), .link(l1.card), .card_state(st[i]), .rca(rc[i]), .push_pull(pp[i]),
         .illegal_cmd(il[i]));
   end
   if (1) begin : g_solo
      cip_card cip_card_inst (.clk(clk), .rst_n(rst_n), .link(l2.card), .card_state(st[2]),
         .rca(rc[2]), .push_pull(pp[2]), .illegal_cmd(il[2]));
   end
   cip_link_chk #(.NCARD(2)) cip_link_chk_inst (.clk(clk), .rst_n(rst_n), .mclk(l1.mclk),
      .host_cmd_o(l1.host_cmd_o), .host_cmd_oe_n(l1.host_cmd_oe_n),
      .card_cmd_o(l1.card_cmd_o), .card_cmd_oe_n(l1.card_cmd_oe_n),
      .card_dat_oe_n(l1.card_dat_oe_n), .cmd(l1.cmd), .dat(l1.dat));
   always #20 clk = ~clk;
   always @(posedge clk) if (il[2] === 1'b1) n_ill++;
   always @(posedge clk) if (il[0] === 1'b1 || il[1] === 1'b1) n_ill_stk++;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // zero wins on the wired line, so the larger identity loses arbitration
   function automatic logic [127:0] lose(input logic [127:0] a, input logic [127:0] b);
      return (a < b) ? b : a;
   endfunction
   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic run(input logic [31:0] w, output int k);
      volt_window = w;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      @(negedge clk);
      for (k = 2; k < 60000 && busy !== 1'b0; k++) @(negedge clk);
      if (k == 60000) begin
         n_fail++;
         end_sim();
      end
   endtask
   // one link period on the bench-driven link; line sampled just before the rise
   task automatic tick(input logic b, input logic oe_n);
      l2.host_cmd_o = b;
      l2.host_cmd_oe_n = oe_n;
      repeat (4) @(negedge clk);
      cap = {cap[62:0], l2.cmd};
      l2.mclk = 1'b1;
      repeat (4) @(negedge clk);
      l2.mclk = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) tick(1'b0, 1'b1);
   endtask
   task automatic send(input logic [47:0] f);
      for (int i = 47; i >= 0; i--) tick(f[i], 1'b0);
   endtask
   initial begin
      int k;
      int n0;
      logic [5:0] bad [18];
      bad = '{6'h05, 6'h06, 6'h08, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h1F, 6'h27, 6'h28, 6'h29,
              6'h2B, 6'h36, 6'h37, 6'h38, 6'h38, 6'h39, 6'h3F};
      rst_n = 1'b0;
      start = 1'b0;
      volt_window = 32'h00000000;
      l2.mclk = 1'b0;
      l2.host_cmd_o = 1'b1;
      l2.host_cmd_oe_n = 1'b1;
      rs = 32'h00004491;
      do_reset();
      rs = xs(rs);
      run((rs & OCR_VOLT_MASK & OCR_READY) | 32'h00008000, k);
      chk("done", done, 1'b1);
      chk("powerup wait", 128'(k > int'(POWERUP_CYCLES)), 128'(1));
      chk("query ocr", ocr_wired, OCR_BUSY);
      chk("unusable", unusable, 1'b0);
      chk("card count", card_count, 8'h02);
      chk("last rca", last_rca, FIRST_RCA + 16'h0001);
      chk("last cid", last_cid, lose(CID_DEFAULT, CID_B) | 128'h1);
      chk("winner rca", rc[CID_B < CID_DEFAULT], FIRST_RCA);
      chk("loser rca", rc[CID_B > CID_DEFAULT], FIRST_RCA + 16'h0001);
      chk("no card flag", no_card, 1'b0);
      chk("stack illegal", 128'(n_ill_stk), 128'(0));
      for (int i = 0; i < 2; i++) begin
         chk("state", st[i], CS_STBY);
         chk("push pull", pp[i], 1'b1);
      end
      do_reset();
      rs = xs(rs);
      run((rs & 32'h00007F00) | 32'h00000100, k);
      chk("out of range", unusable, 1'b1);
      chk("no cards named", card_count, 8'h00);
      chk("no answer flag", no_card, 1'b1);
      for (int i = 0; i < 2; i++) begin
         chk("inactive", st[i], CS_INACTIVE);
      end
      foreach (bad[j]) begin
         rs = xs(rs);
         n0 = n_ill;
         send(cip_frame(1'b1, bad[j], {rs[31:1], j[0]}, 1'b1));
         idle(8);
         chk("illegal pulse", 128'(n_ill - n0), 128'(1));
         chk("state kept", st[2], CS_IDLE);
      end
      send(cip_frame(1'b1, CMD_APP_PREFIX, 32'h00000000, 1'b1));
      idle(8);
      send(cip_frame(1'b1, CMD_SEND_OP_COND, 32'h00FF8000, 1'b1));
      idle(50);
      chk("op answer", cap[47:0], {2'b00, RSP_LONG_INDEX, OCR_READY, 7'h7F, 1'b1});
      chk("ready", st[2], CS_READY);
      idle(8);
      send(cip_frame(1'b1, CMD_ALL_SEND_ID, 32'h00000000, 1'b1));
      idle(138);
      chk("id tail", cap, {CID_DEFAULT[63:1], 1'b1});
      // the card ends its frame on the link fall that closes the last idle period
      repeat (4) @(negedge clk);
      chk("ident", st[2], CS_IDENT);
      idle(8);
      send(cip_frame(1'b1, CMD_SET_REL_ADDR, 32'h00050000, 1'b1));
      idle(58);
      chk("rca", rc[2], 16'h0005);
      chk("push pull", pp[2], 1'b1);
      send(cip_frame(1'b1, CMD_ALL_SEND_ID, 32'h00000000, 1'b1));
      idle(10);
      chk("no answer", cap[9:0], 10'h3FF);
      chk("standby", st[2], CS_STBY);
      end_sim();
   end
endmodule // card_identification_protocol_tb
